// File: pioc_map.vh
// Register map, reset values and widths of the parallel I/O line controller.
// Assumes inclusion by the controller files only; definitions only.
`ifndef PIOC_MAP_VH
`define PIOC_MAP_VH
`define PIOC_OWN_EN     8'h00
`define PIOC_OWN_DIS    8'h04
`define PIOC_OWN_ST     8'h08
`define PIOC_DRV_EN     8'h10
`define PIOC_DRV_DIS    8'h14
`define PIOC_DRV_ST     8'h18
`define PIOC_FLT_EN     8'h20
`define PIOC_FLT_DIS    8'h24
`define PIOC_FLT_ST     8'h28
`define PIOC_OUT_SET    8'h30
`define PIOC_OUT_CLR    8'h34
`define PIOC_OUT_ST     8'h38
`define PIOC_PIN_ST     8'h3c
`define PIOC_IRQ_EN     8'h40
`define PIOC_IRQ_DIS    8'h44
`define PIOC_IRQ_MASK   8'h48
`define PIOC_IRQ_ST     8'h4c
`define PIOC_OD_EN      8'h50
`define PIOC_OD_DIS     8'h54
`define PIOC_OD_ST      8'h58
`define PIOC_PU_DIS     8'h60
`define PIOC_PU_EN      8'h64
`define PIOC_PU_ST      8'h68
`define PIOC_SEL_A      8'h70
`define PIOC_SEL_B      8'h74
`define PIOC_SEL_ST     8'h78
`define PIOC_WM_EN      8'ha0
`define PIOC_WM_DIS     8'ha4
`define PIOC_WM_ST      8'ha8
`define PIOC_ADDR_W     8
`define PIOC_ZERO       32'h00000000
`define PIOC_RESP_OKAY  2'b00
`define PIOC_RESP_SLV   2'b10
`endif

// File: pioc_setclr.v
// One set/clear status register: a bit set by one write, cleared by another.
// Assumes one-cycle write strobes from the bus slave and a line mask.
`timescale 1ns/1ps
module pioc_setclr #(
   parameter            W     = 32,
   parameter [W-1:0]    RST   = {W{1'b0}},
   parameter [W-1:0]    LINES = {W{1'b1}}
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire          set_stb,
   input  wire          clr_stb,
   input  wire [W-1:0]  wdata,
   output wire [W-1:0]  status
);
   reg  [W-1:0] st_q;
   wire [W-1:0] st_d;
   // Bits written 0 keep their value; absent lines are never touched.
   assign st_d = (st_q | ({W{set_stb}} & wdata & LINES)) & ~({W{clr_stb}} & wdata & LINES);
   always @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= RST & LINES;
      end else begin
         st_q <= st_d;
      end
   end
   assign status = st_q;
endmodule

// File: pioc_infilt.v
// Input sampling stage for the pin level: optional one-cycle glitch filter.
// Assumes pin levels synchronous to aclk, as the pad ring provides.
`timescale 1ns/1ps
module pioc_infilt #(
   parameter            W = 32
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [W-1:0]  pin_in,
   input  wire [W-1:0]  filt_en,
   output wire [W-1:0]  level
);
   reg [W-1:0] s1_q;
   reg [W-1:0] lvl_q;
   // A filtered line follows only a level held for two samples in a row.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_q  <= {W{1'b0}};
         lvl_q <= {W{1'b0}};
      end else begin
         s1_q  <= pin_in;
         lvl_q <= (~filt_en & pin_in) | (filt_en & ~(s1_q ^ pin_in) & pin_in) |
                  (filt_en & (s1_q ^ pin_in) & lvl_q);
      end
   end
   assign level = lvl_q;
endmodule

// File: pioc_top.v
// Top of the parallel I/O line controller: AXI4-Lite slave, line state, pads.
// Assumes pad inputs and peripheral outputs synchronous to aclk.
//
// Notes on behaviour
// - Every register is one 32-bit word, one bit per line.
// - Bits of absent lines ignore writes and read zero.
// - Lines without a peripheral stay controller-owned and read ownership 1.
// - Ownership-enable write gives controller the pins written 1.
// - Ownership-disable write hands pins written 1 to the peripheral.
// - Ownership status resets to a configured value.
// - Ownership 1 means controller drives, 0 means peripheral active.
// - Glitch-filter enable, disable, status at 0x20, 0x24, 0x28; reset zero.
// - Output data status resets zero; direct writes only on masked-in lines.
// - Pin level status returns the live line levels, no fixed reset.
// - Change status resets zero but may already hold changes.
// - Reading change status clears all pending flags at once.
// - First-select clears A/B status bit; second-select sets it.
// - A/B status 0 routes peripheral A output, 1 peripheral B.
// - Pull-up disable, enable, status at 0x60, 0x64, 0x68; reset zero.
// - Write-mask enable, disable, status at 0xa0..0xa8; reset zero.
// - Pin level status sits at 0x3c after output data status.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pioc_map.vh"
module pioc_top #(
   parameter          N        = 32,
   parameter [31:0]   LINES    = 32'hffffffff,
   parameter [31:0]   MUXED    = 32'hffffffff,
   parameter [31:0]   OWN_RST  = 32'hffffffff
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [31:0]   s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [31:0]   s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   input  wire [31:0]   pin_in,
   output reg  [31:0]   pin_out,
   output reg  [31:0]   pin_oe_n,
   output reg  [31:0]   pin_pullup,
   input  wire [31:0]   periph_a_out,
   input  wire [31:0]   periph_a_oe,
   input  wire [31:0]   periph_b_out,
   input  wire [31:0]   periph_b_oe,
   output reg           irq
);
   // ------------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------------
   reg  [7:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   reg         aw_have_q;
   reg         w_have_q;
   wire        do_wr;
   wire [7:0]  wa;
   wire [31:0] wd;
   wire        wmap;
   wire        wr_full;
   assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wa    = awaddr_q;
   // Partial strobes would break set/clear semantics; only full words act.
   assign wr_full = (wstrb_q == 4'hf);
   assign wd    = wdata_q & LINES;
   always @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q      <= 8'h00;
         wdata_q       <= `PIOC_ZERO;
         wstrb_q       <= 4'h0;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PIOC_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q  <= s_axi_awaddr[7:0];
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
         if (do_wr) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wmap ? `PIOC_RESP_OKAY : `PIOC_RESP_SLV;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   function wstb;
      input [7:0] off;
      begin
         wstb = do_wr && wr_full && wmap && (wa == off);
      end
   endfunction
   // ------------------------------------------------------------------
   // Write strobes
   // ------------------------------------------------------------------
   // A refused write raises no strobe, so an alias above 0xff changes nothing.
   wire        own_set_stb = wstb(`PIOC_OWN_EN);
   wire        own_clr_stb = wstb(`PIOC_OWN_DIS);
   wire        drv_set_stb = wstb(`PIOC_DRV_EN);
   wire        drv_clr_stb = wstb(`PIOC_DRV_DIS);
   wire        flt_set_stb = wstb(`PIOC_FLT_EN);
   wire        flt_clr_stb = wstb(`PIOC_FLT_DIS);
   wire        msk_set_stb = wstb(`PIOC_IRQ_EN);
   wire        msk_clr_stb = wstb(`PIOC_IRQ_DIS);
   wire        od_set_stb  = wstb(`PIOC_OD_EN);
   wire        od_clr_stb  = wstb(`PIOC_OD_DIS);
   wire        pu_set_stb  = wstb(`PIOC_PU_EN);
   wire        pu_clr_stb  = wstb(`PIOC_PU_DIS);
   wire        sel_set_stb = wstb(`PIOC_SEL_B);
   wire        sel_clr_stb = wstb(`PIOC_SEL_A);
   wire        wm_set_stb  = wstb(`PIOC_WM_EN);
   wire        wm_clr_stb  = wstb(`PIOC_WM_DIS);
   // ------------------------------------------------------------------
   // Line state registers
   // ------------------------------------------------------------------
   wire [31:0] own_st;
   wire [31:0] drv_st;
   wire [31:0] flt_st;
   wire [31:0] od_st;
   wire [31:0] pu_st;
   wire [31:0] sel_st;
   wire [31:0] wm_st;
   wire [31:0] msk_st;
   wire [31:0] own_raw;
   wire [31:0] level;
   reg  [31:0] out_q;
   reg  [31:0] prev_q;
   reg  [31:0] chg_q;
   pioc_setclr #(.W(32), .RST(OWN_RST), .LINES(LINES & MUXED)) u_own (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_stb (own_set_stb),
      .clr_stb (own_clr_stb),
      .wdata   (wd),
      .status  (own_raw)
   );
   // Unmuxed lines are always controller-owned.
   assign own_st = (own_raw | ~MUXED) & LINES;
   pioc_setclr #(.W(32), .LINES(LINES)) u_drv (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_stb (drv_set_stb),
      .clr_stb (drv_clr_stb),
      .wdata   (wd),
      .status  (drv_st)
   );
   pioc_setclr #(.W(32), .LINES(LINES)) u_flt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_stb (flt_set_stb),
      .clr_stb (flt_clr_stb),
      .wdata   (wd),
      .status  (flt_st)
   );
   pioc_setclr #(.W(32), .LINES(LINES)) u_msk (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_stb (msk_set_stb),
      .clr_stb (msk_clr_stb),
      .wdata   (wd),
      .status  (msk_st)
   );
   pioc_setclr #(.W(32), .LINES(LINES)) u_od (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_stb (od_set_stb),
      .clr_stb (od_clr_stb),
      .wdata   (wd),
      .status  (od_st)
   );
   pioc_setclr #(.W(32), .LINES(LINES)) u_pu (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_stb (pu_set_stb),
      .clr_stb (pu_clr_stb),
      .wdata   (wd),
      .status  (pu_st)
   );
   pioc_setclr #(.W(32), .LINES(LINES)) u_sel (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_stb (sel_set_stb),
      .clr_stb (sel_clr_stb),
      .wdata   (wd),
      .status  (sel_st)
   );
   pioc_setclr #(.W(32), .LINES(LINES)) u_wm (
      .aclk    (aclk),
      .aresetn (aresetn),
      .set_stb (wm_set_stb),
      .clr_stb (wm_clr_stb),
      .wdata   (wd),
      .status  (wm_st)
   );
   pioc_infilt #(.W(32)) u_in (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  (pin_in),
      .filt_en (flt_st),
      .level   (level)
   );
   // ------------------------------------------------------------------
   // Output data and input change detection
   // ------------------------------------------------------------------
   wire [31:0] chg_ev;
   wire        isr_rd;
   assign chg_ev = (level ^ prev_q) & LINES;
   always @(posedge aclk) begin
      if (!aresetn) begin
         out_q  <= `PIOC_ZERO;
         prev_q <= `PIOC_ZERO;
         chg_q  <= `PIOC_ZERO;
      end else begin
         prev_q <= level;
         if (wstb(`PIOC_OUT_SET)) begin
            out_q <= out_q | wd;
         end else if (wstb(`PIOC_OUT_CLR)) begin
            out_q <= out_q & ~wd;
         end else if (wstb(`PIOC_OUT_ST)) begin
            out_q <= (out_q & ~wm_st) | (wd & wm_st);
         end
         // A change arriving in the read's own cycle survives the clear.
         if (isr_rd) begin
            chg_q <= chg_ev;
         end else begin
            chg_q <= chg_q | chg_ev;
         end
      end
   end
   // ------------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------------
   reg  [31:0] rmux;
   reg         rmap;
   assign isr_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:0] == `PIOC_IRQ_ST) &&
                   (s_axi_araddr[31:8] == 24'h000000);
   always @* begin
      rmap = 1'b1;
      rmux = `PIOC_ZERO;
      case (s_axi_araddr[7:0])
         `PIOC_OWN_ST   : rmux = own_st;
         `PIOC_DRV_ST   : rmux = drv_st;
         `PIOC_FLT_ST   : rmux = flt_st;
         `PIOC_OUT_ST   : rmux = out_q;
         `PIOC_PIN_ST   : rmux = level & LINES;
         `PIOC_IRQ_MASK : rmux = msk_st;
         `PIOC_IRQ_ST   : rmux = chg_q;
         `PIOC_OD_ST    : rmux = od_st;
         `PIOC_PU_ST    : rmux = pu_st;
         `PIOC_SEL_ST   : rmux = sel_st;
         `PIOC_WM_ST    : rmux = wm_st;
         `PIOC_OWN_EN, `PIOC_OWN_DIS, `PIOC_DRV_EN, `PIOC_DRV_DIS, `PIOC_FLT_EN,
         `PIOC_FLT_DIS, `PIOC_OUT_SET, `PIOC_OUT_CLR, `PIOC_IRQ_EN, `PIOC_IRQ_DIS,
         `PIOC_OD_EN, `PIOC_OD_DIS, `PIOC_PU_DIS, `PIOC_PU_EN, `PIOC_SEL_A,
         `PIOC_SEL_B, `PIOC_WM_EN, `PIOC_WM_DIS : rmux = `PIOC_ZERO;
         default        : rmap = 1'b0;
      endcase
      if (s_axi_araddr[31:8] != 24'h000000) begin
         rmap = 1'b0;
         rmux = `PIOC_ZERO;
      end
   end
   reg wmap_r;
   always @* begin
      wmap_r = 1'b1;
      case (wa)
         `PIOC_OWN_EN, `PIOC_OWN_DIS, `PIOC_OWN_ST, `PIOC_DRV_EN, `PIOC_DRV_DIS,
         `PIOC_DRV_ST, `PIOC_FLT_EN, `PIOC_FLT_DIS, `PIOC_FLT_ST, `PIOC_OUT_SET,
         `PIOC_OUT_CLR, `PIOC_OUT_ST, `PIOC_PIN_ST, `PIOC_IRQ_EN, `PIOC_IRQ_DIS,
         `PIOC_IRQ_MASK, `PIOC_IRQ_ST, `PIOC_OD_EN, `PIOC_OD_DIS, `PIOC_OD_ST,
         `PIOC_PU_DIS, `PIOC_PU_EN, `PIOC_PU_ST, `PIOC_SEL_A, `PIOC_SEL_B,
         `PIOC_SEL_ST, `PIOC_WM_EN, `PIOC_WM_DIS, `PIOC_WM_ST : wmap_r = 1'b1;
         default : wmap_r = 1'b0;
      endcase
   end
   reg aw_hi_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hi_q <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hi_q <= (s_axi_awaddr[31:8] != 24'h000000);
      end
   end
   assign wmap = wmap_r && !aw_hi_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `PIOC_ZERO;
         s_axi_rresp   <= `PIOC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rmux;
            s_axi_rresp  <= rmap ? `PIOC_RESP_OKAY : `PIOC_RESP_SLV;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // ------------------------------------------------------------------
   // Pads and interrupt
   // ------------------------------------------------------------------
   wire [31:0] p_oe;
   wire [31:0] drv_val;
   wire [31:0] drv_on;
   assign drv_val = (own_st & out_q) |
                    (~own_st & ((~sel_st & periph_a_out) | (sel_st & periph_b_out)));
   assign p_oe    = (own_st & drv_st) |
                    (~own_st & ((~sel_st & periph_a_oe) | (sel_st & periph_b_oe)));
   // Open-drain lines only pull low; a high level is left to the pull-up.
   assign drv_on  = p_oe & ~(od_st & drv_val) & LINES;
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_out    <= `PIOC_ZERO;
         pin_oe_n   <= 32'hffffffff;
         pin_pullup <= `PIOC_ZERO;
         irq        <= 1'b0;
      end else begin
         pin_out    <= drv_val & LINES;
         pin_oe_n   <= ~drv_on;
         pin_pullup <= pu_st;
         irq        <= |(chg_q & msk_st);
      end
   end
endmodule

// File: pioc_pads.sv
// Pad and peripheral model on the line side of the controller.
// Assumes an outside driver holds every line that the controller releases.
`timescale 1ns/1ps
module pioc_pads (
   input  wire [31:0] pin_out,
   input  wire [31:0] pin_oe_n,
   input  wire [31:0] ext_lvl,
   output wire [31:0] pin_in,
   output wire [31:0] periph_a_out,
   output wire [31:0] periph_a_oe,
   output wire [31:0] periph_b_out,
   output wire [31:0] periph_b_oe
);
   // A released line shows the outside level, never a stale copy of the output.
   assign pin_in       = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
   // The peripherals drive opposite levels so that the routing shows at the pad.
   assign periph_a_out = 32'h0;
   assign periph_a_oe  = 32'hffffffff;
   assign periph_b_out = 32'hffffffff;
   assign periph_b_oe  = 32'hffffffff;
endmodule

// File: pioc_props.sv
// Checker of the bus handshakes, pull-up and interrupt ports of the controller.
// Assumes binding to pioc_top, one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module pioc_props (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire [31:0] pin_pullup,
   input wire        irq
);
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_hs;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_soon;
      ##[1:3] s_axi_bvalid;
   endsequence
   property p_wr_ans; s_wr_hs |-> s_b_soon; endproperty
   property p_rd_ans; ar_hs |=> s_axi_rvalid; endproperty
   property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
   property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
   property p_err_zero; s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0; endproperty
   // Pull-up enables move only as a register write completes.
   property p_pu_wr; !$stable(pin_pullup) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
   // The interrupt drops only after a status read or a mask write.
   property p_irq_fall;
      $fell(irq) |-> $past(ar_hs) || $past(ar_hs, 2) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("late write answer");
   a_rd_ans: assert property (p_rd_ans) else $error("late read answer");
   a_r_drop: assert property (p_r_drop) else $error("read answer held");
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
   a_ar_pulse: assert property (p_ar_pulse) else $error("arready held");
   a_err_zero: assert property (p_err_zero) else $error("error read data");
   a_pu_wr: assert property (p_pu_wr) else $error("pull-up moved alone");
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule
bind pioc_top pioc_props i_pioc_props (.*);

// File: pioc_bench.sv
// Self-checking bench of the line controller through its register bus and pads.
// Assumes pioc_top, pioc_pads and the bound checker are compiled with it.
`timescale 1ns/1ps
`define CHK(g, w) begin \
   total_checks++; \
   if ((g) !== (w)) begin \
      bad_count++; \
      $display("unexpected at %0t got %h want %h", $time, g, w); \
   end \
end
module pioc_bench;
   localparam [31:0] LN = 32'h7fffffff;
   localparam [31:0] MX = 32'h3fffffff;
   logic        aclk;
   logic        aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1;
   logic        s_axi_rready = 1'b1;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [31:0] ext_lvl = 32'h0;
   wire  [31:0] s_axi_rdata, pin_in, pin_out, pin_oe_n, pin_pullup;
   wire  [31:0] periph_a_out, periph_a_oe, periph_b_out, periph_b_oe;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire         s_axi_arready, s_axi_rvalid, irq;
   int          bad_count = 0;
   int          total_checks = 0;
   logic [7:0]  zr[13] = '{8'h00, 8'h30, 8'h64, 8'ha4, 8'h18, 8'h28, 8'h38,
                           8'h48, 8'h4c, 8'h58, 8'h68, 8'h78, 8'ha8};
   pioc_top #(.LINES(LN), .MUXED(MX)) i_pioc_top (.*);
   pioc_pads i_pioc_pads (.*);
   // Bus cycles: both write channels are offered together; waits end on the answer.
   task automatic wr(input logic [31:0] a, d, input logic [1:0] er = 2'b00);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      `CHK(s_axi_bresp, er)
   endtask
   task automatic rd(input logic [31:0] a, d, input logic [1:0] er = 2'b00);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      `CHK(s_axi_rdata, d)
      `CHK(s_axi_rresp, er)
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      #100000;
      bad_count++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK(pin_oe_n, 32'hffffffff)
      `CHK({pin_out, pin_pullup, irq}, 65'h0)
      foreach (zr[i]) rd(zr[i], 32'h0);
      ext_lvl <= 32'h8000ab00;
      rd(8'h08, LN);
      wr(8'h04, 32'hffffffff);
      rd(8'h08, LN & ~MX);
      wr(8'h00, 32'hf);
      wr(8'h00, 32'h0);
      rd(8'h08, 32'h4000000f);
      wr(8'h00, 32'hffffffff);
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'hffffffff, 2'b10);
      rd(8'h0c, 32'h0, 2'b10);
      rd(32'h108, 32'h0, 2'b10);
      rd(8'h08, LN);
      wr(8'h10, 32'h800000ff);
      rd(8'h18, 32'hff);
      wr(8'h30, 32'h80000055);
      wr(8'h38, 32'haa);
      rd(8'h38, 32'h55);
      wr(8'ha0, 32'hf);
      rd(8'ha8, 32'hf);
      wr(8'h38, 32'haa);
      rd(8'h38, 32'h5a);
      `CHK(pin_out[7:0], 8'h5a)
      `CHK(pin_oe_n[7:0], 8'h0)
      rd(8'h3c, 32'hab5a);
      wr(8'h20, 32'h300);
      wr(8'h24, 32'h100);
      rd(8'h28, 32'h200);
      wr(8'h64, 32'h300);
      wr(8'h60, 32'h100);
      rd(8'h68, 32'h200);
      `CHK(pin_pullup, 32'h200)
      wr(8'h04, 32'h10);
      rd(8'h08, 32'h7fffffef);
      `CHK({pin_out[4], pin_oe_n[4]}, 2'b00)
      wr(8'h74, 32'h10);
      rd(8'h78, 32'h10);
      `CHK({pin_out[4], pin_oe_n[4]}, 2'b10)
      wr(8'h70, 32'h10);
      rd(8'h78, 32'h0);
      `CHK(pin_out[4], 1'b0)
      wr(8'h00, 32'h10);
      wr(8'h40, 32'h100);
      rd(8'h48, 32'h100);
      rd(8'h4c, 32'hab5f);
      ext_lvl <= 32'h8000a800;
      repeat (6) @(posedge aclk);
      `CHK(irq, 1'b1)
      rd(8'h4c, 32'h300);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      ext_lvl <= 32'h8000aa00;
      repeat (6) @(posedge aclk);
      `CHK(irq, 1'b0)
      ext_lvl <= 32'h8000ab00;
      repeat (6) @(posedge aclk);
      `CHK(irq, 1'b1)
      wr(8'h44, 32'h100);
      rd(8'h48, 32'h0);
      `CHK(irq, 1'b0)
      rd(8'h4c, 32'h300);
      ext_lvl <= 32'h8000a800;
      @(posedge aclk);
      ext_lvl <= 32'h8000ab00;
      repeat (4) @(posedge aclk);
      rd(8'h4c, 32'h100);
      s_axi_wstrb <= 4'h1;
      wr(8'h14, 32'hff);
      s_axi_wstrb <= 4'hf;
      rd(8'h18, 32'hff);
      wr(8'h50, 32'h3);
      rd(8'h58, 32'h3);
      `CHK(pin_oe_n[1:0], 2'b10)
      wr(8'h14, 32'hff);
      rd(8'h18, 32'h0);
      `CHK(pin_oe_n[7:0], 8'hff)
      close_out();
   end
endmodule
